/* src/omm_defines.svh */
// Address map, sizes and reset values of the on-chip memory map decoder
`ifndef OMM_DEFINES_SVH
`define OMM_DEFINES_SVH

// ****************************************************************
// Data space map
// ****************************************************************
`define OMM_RAM_LAST    16'h1FFF
`define OMM_SCR_BASE    16'hE000
`define OMM_SCR_LAST    16'hE1FF
`define OMM_WAVE_BASE   16'hE400
`define OMM_WAVE_LAST   16'hE47F
`define OMM_REG_BASE    16'hE600
`define OMM_REG_LAST    16'hE6FF
`define OMM_SETUP_BASE  16'hE6B8
`define OMM_SETUP_LAST  16'hE6BF
`define OMM_EP0_BASE    16'hE740
`define OMM_EP0_LAST    16'hE77F
`define OMM_EP1O_BASE   16'hE780
`define OMM_EP1O_LAST   16'hE7BF
`define OMM_EP1I_BASE   16'hE7C0
`define OMM_EP1I_LAST   16'hE7FF
`define OMM_EPB_BASE    16'hF000

// ****************************************************************
// Storage depths
// ****************************************************************
`define OMM_RAM_DEPTH   8192
`define OMM_SCR_DEPTH   512
`define OMM_WAVE_DEPTH  128
`define OMM_SETUP_DEPTH 8

// ****************************************************************
// Endpoint buffer identifiers and sizes
// ****************************************************************
`define OMM_BUF_EP0     4'h0
`define OMM_BUF_EP1O    4'h1
`define OMM_BUF_EP1I    4'h2
`define OMM_SIZE_FS     7'h40
`define OMM_SIZE_NONE   7'h00

// ****************************************************************
// Endpoint configuration reset value and column limit
// ****************************************************************
`define OMM_CFG_RST_BUF 3'h2
`define OMM_CFG_COL_MAX 1'h1

`endif

/* src/omm_pkg.sv */
// Types shared by the on-chip memory map decoder files
`default_nettype none
package omm_pkg;

  typedef enum logic [3:0] {
    OMM_RG_INTRAM, OMM_RG_EXT, OMM_RG_SCRATCH, OMM_RG_WAVE, OMM_RG_SETUP,
    OMM_RG_REGS, OMM_RG_EP0, OMM_RG_EP1O, OMM_RG_EP1I, OMM_RG_EPBIG,
    OMM_RG_RESV
  } omm_region_t;

  typedef enum logic [1:0] {OMM_CTRL, OMM_ISO, OMM_BULK, OMM_INT} omm_xfer_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        fetch;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } omm_cpu_req_t;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } omm_ldr_req_t;

  typedef struct packed {
    logic       sel;
    logic       wr;
    logic [3:0] buf_id;
    logic [8:0] offset;
    logic [7:0] wdata;
  } omm_eng_acc_t;

  typedef struct packed {
    logic       wr;
    logic [2:0] idx;
    logic [7:0] data;
  } omm_setup_wr_t;

  typedef struct packed {
    logic      shared;
    logic      col;
    logic [2:0] buf2;
    logic [2:0] buf6;
    omm_xfer_t ty1;
    omm_xfer_t ty2;
    omm_xfer_t ty4;
    omm_xfer_t ty6;
    omm_xfer_t ty8;
  } omm_ep_cfg_t;

  typedef struct packed {
    logic [2:0] n2;
    logic [2:0] n4;
    logic [2:0] n6;
    logic [2:0] n8;
  } omm_blk_t;

  typedef struct packed {
    logic [6:0] size;
    omm_xfer_t  xfer;
    logic       dbl;
  } omm_alt_ep_t;

  typedef struct packed {
    omm_alt_ep_t ep0;
    omm_alt_ep_t ep1o;
    omm_alt_ep_t ep1i;
    omm_alt_ep_t ep2;
    omm_alt_ep_t ep4;
    omm_alt_ep_t ep6;
    omm_alt_ep_t ep8;
  } omm_alt_row_t;

endpackage : omm_pkg
`default_nettype wire

/* src/omm_ep_cfg.sv */
// Endpoint buffer configuration checker and holder
`timescale 1ns/10ps
`default_nettype none
`include "omm_defines.svh"
module omm_ep_cfg import omm_pkg::*; (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_cfg_wr,
  input  wire omm_ep_cfg_t i_cfg,
  output var  omm_blk_t    o_blk,
  output var  omm_ep_cfg_t o_cfg,
  output var  logic        o_cfg_err
);

  logic ty_ok;
  logic buf_ok;
  omm_blk_t blk_nxt;

  function automatic logic grp_ok(input logic [2:0] n);
    grp_ok = (n >= 3'h2) && (n <= 3'h4);
  endfunction : grp_ok

  function automatic logic [2:0] partner_blocks(input logic [2:0] n);
    partner_blocks = (n == 3'h2) ? 3'h2 : 3'h0;
  endfunction : partner_blocks

  always_comb begin
    ty_ok = (i_cfg.ty1 == OMM_BULK || i_cfg.ty1 == OMM_INT) &&
            i_cfg.ty2 != OMM_CTRL && i_cfg.ty4 != OMM_CTRL &&
            i_cfg.ty6 != OMM_CTRL && i_cfg.ty8 != OMM_CTRL;
    if (i_cfg.shared) begin
      buf_ok = (i_cfg.col <= `OMM_CFG_COL_MAX);
      // Whole columns only; the group fields are ignored here
      blk_nxt = i_cfg.col ? '{3'h3, 3'h2, 3'h3, 3'h0} :
                            '{3'h3, 3'h0, 3'h3, 3'h2};
    end else begin
      buf_ok = grp_ok(i_cfg.buf2) && grp_ok(i_cfg.buf6);
      blk_nxt = '{i_cfg.buf2, partner_blocks(i_cfg.buf2),
                  i_cfg.buf6, partner_blocks(i_cfg.buf6)};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_blk <= '{`OMM_CFG_RST_BUF, `OMM_CFG_RST_BUF,
                 `OMM_CFG_RST_BUF, `OMM_CFG_RST_BUF};
      o_cfg <= '{1'b0, 1'b0, `OMM_CFG_RST_BUF, `OMM_CFG_RST_BUF,
                 OMM_BULK, OMM_BULK, OMM_BULK, OMM_BULK, OMM_BULK};
    end else if (i_cfg_wr && ty_ok && buf_ok) begin
      o_blk <= blk_nxt;
      o_cfg <= i_cfg;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) o_cfg_err <= 1'b0;
    else o_cfg_err <= i_cfg_wr && !(ty_ok && buf_ok);
  end

  property p_ep1_type;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_cfg_wr && (i_cfg.ty1 == OMM_CTRL || i_cfg.ty1 == OMM_ISO))
      |=> o_cfg_err && $stable(o_cfg);
  endproperty
  a_ep1_type: assert property (p_ep1_type)
    else $error("endpoint 1 accepted a control or iso type");

  property p_col_only;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    ($past(i_cfg_wr) && !o_cfg_err)
      |-> (o_blk.n2 + o_blk.n4 + o_blk.n6 + o_blk.n8) <= 5'h08;
  endproperty
  a_col_only: assert property (p_col_only)
    else $error("endpoint blocks exceed the eight buffers");

endmodule : omm_ep_cfg
`default_nettype wire

/* src/omm_alt_rom.sv */
// Default full-speed alternate setting table
`timescale 1ns/10ps
`default_nettype none
`include "omm_defines.svh"
module omm_alt_rom import omm_pkg::*; (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst_b,
  input  wire logic [1:0]   i_alt,
  output var  omm_alt_row_t o_row
);

  localparam omm_alt_ep_t NONE = '{`OMM_SIZE_NONE, OMM_BULK, 1'b0};
  localparam omm_alt_ep_t EP0  = '{`OMM_SIZE_FS, OMM_CTRL, 1'b0};

  function automatic omm_alt_ep_t ep(input omm_xfer_t t, input logic d);
    ep = '{`OMM_SIZE_FS, t, d};
  endfunction : ep

  omm_alt_row_t row_nxt;

  always_comb begin
    case (i_alt)
      2'h1: row_nxt = '{EP0, ep(OMM_BULK, 1'b0), ep(OMM_BULK, 1'b0),
                        ep(OMM_BULK, 1'b1), ep(OMM_BULK, 1'b1),
                        ep(OMM_BULK, 1'b1), ep(OMM_BULK, 1'b1)};
      2'h2: row_nxt = '{EP0, ep(OMM_INT, 1'b0), ep(OMM_INT, 1'b0),
                        ep(OMM_INT, 1'b1), ep(OMM_BULK, 1'b1),
                        ep(OMM_INT, 1'b1), ep(OMM_BULK, 1'b1)};
      2'h3: row_nxt = '{EP0, ep(OMM_INT, 1'b0), ep(OMM_INT, 1'b0),
                        ep(OMM_ISO, 1'b1), ep(OMM_BULK, 1'b1),
                        ep(OMM_ISO, 1'b1), ep(OMM_BULK, 1'b1)};
      default: row_nxt = '{EP0, NONE, NONE, NONE, NONE, NONE, NONE};
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) o_row <= '{EP0, NONE, NONE, NONE, NONE, NONE, NONE};
    else o_row <= row_nxt;
  end

  property p_alt0;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_alt == 2'h0) |=> o_row.ep1o.size == `OMM_SIZE_NONE &&
                        o_row.ep0.size == `OMM_SIZE_FS;
  endproperty
  a_alt0: assert property (p_alt0)
    else $error("setting 0 reports an implemented endpoint");

endmodule : omm_alt_rom
`default_nettype wire

/* src/omm_decode.sv */
// On-chip memory map decoder, internal memories and endpoint setup
// ****************************************************************
// ****************************************************************
`timescale 1ns/10ps
`default_nettype none
`include "omm_defines.svh"
module omm_decode import omm_pkg::*; (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst_b,
  input  wire logic          i_code_source_select,
  input  wire omm_cpu_req_t  i_cpu,
  output var  logic [7:0]    o_cpu_rdata,
  output var  logic          o_cpu_rvalid,
  output var  logic          o_ext_fetch,
  output var  logic          o_ext_rd,
  output var  logic          o_ext_wr,
  input  wire logic [7:0]    i_ext_rdata,
  output var  logic          o_reg_rd,
  output var  logic          o_reg_wr,
  input  wire logic [7:0]    i_reg_rdata,
  output var  omm_eng_acc_t  o_eng,
  input  wire logic [7:0]    i_eng_rdata,
  input  wire omm_setup_wr_t i_setup,
  input  wire omm_ldr_req_t  i_ldr,
  output var  logic [7:0]    o_ldr_rdata,
  output var  logic          o_ldr_ack,
  output var  logic          o_ldr_err,
  input  wire logic          i_cfg_wr,
  input  wire omm_ep_cfg_t   i_cfg,
  output var  omm_blk_t      o_blk,
  output var  omm_ep_cfg_t   o_cfg,
  output var  logic          o_cfg_err,
  input  wire logic [1:0]    i_alt,
  output var  omm_alt_row_t  o_alt_row
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic omm_region_t region_of(input logic [15:0] a);
    if (a <= `OMM_RAM_LAST) region_of = OMM_RG_INTRAM;
    else if (a < `OMM_SCR_BASE) region_of = OMM_RG_EXT;
    else if (a <= `OMM_SCR_LAST) region_of = OMM_RG_SCRATCH;
    else if (a >= `OMM_WAVE_BASE && a <= `OMM_WAVE_LAST)
      region_of = OMM_RG_WAVE;
    else if (a >= `OMM_SETUP_BASE && a <= `OMM_SETUP_LAST)
      region_of = OMM_RG_SETUP;
    else if (a >= `OMM_REG_BASE && a <= `OMM_REG_LAST)
      region_of = OMM_RG_REGS;
    else if (a >= `OMM_EP0_BASE && a <= `OMM_EP0_LAST)
      region_of = OMM_RG_EP0;
    else if (a >= `OMM_EP1O_BASE && a <= `OMM_EP1O_LAST)
      region_of = OMM_RG_EP1O;
    else if (a >= `OMM_EP1I_BASE && a <= `OMM_EP1I_LAST)
      region_of = OMM_RG_EP1I;
    else if (a >= `OMM_EPB_BASE) region_of = OMM_RG_EPBIG;
    else region_of = OMM_RG_RESV;
  endfunction : region_of

  omm_region_t cpu_rg;
  omm_region_t ldr_rg;
  logic        fetch_int;
  logic        ram_rd;
  logic        ldr_ok;
  logic        is_eng;
  logic [7:0]  cpu_val;

  assign cpu_rg    = region_of(i_cpu.addr);
  assign ldr_rg    = region_of(i_ldr.addr);
  // Internal program space exists only with the select low
  assign fetch_int = i_cpu.fetch && !i_code_source_select &&
                     cpu_rg == OMM_RG_INTRAM;
  assign ram_rd    = (fetch_int || i_cpu.rd) && cpu_rg == OMM_RG_INTRAM;
  assign ldr_ok    = i_ldr.req && (ldr_rg == OMM_RG_INTRAM ||
                                   ldr_rg == OMM_RG_SCRATCH);
  assign is_eng    = cpu_rg == OMM_RG_EP0 || cpu_rg == OMM_RG_EP1O ||
                     cpu_rg == OMM_RG_EP1I || cpu_rg == OMM_RG_EPBIG;

  // ****************************************************************
  // External strobes and register page
  // ****************************************************************
  // Any fetch outside internal code space goes to the external part
  assign o_ext_fetch = i_cpu.fetch && !fetch_int;
  // Reserved gaps also keep the strobes low, so a full 64 KB part
  // never answers a read or write inside the upper on-chip window
  assign o_ext_rd = i_cpu.rd && cpu_rg == OMM_RG_EXT;
  assign o_ext_wr = i_cpu.wr && cpu_rg == OMM_RG_EXT;
  assign o_reg_rd = i_cpu.rd && cpu_rg == OMM_RG_REGS;
  assign o_reg_wr = i_cpu.wr && cpu_rg == OMM_RG_REGS;

  // ****************************************************************
  // Endpoint buffer access towards the USB engine
  // ****************************************************************
  always_comb begin
    o_eng.sel    = is_eng && (i_cpu.rd || i_cpu.wr);
    o_eng.wr     = is_eng && i_cpu.wr;
    o_eng.wdata  = i_cpu.wdata;
    o_eng.offset = {3'h0, i_cpu.addr[5:0]};
    case (cpu_rg)
      OMM_RG_EP0:  o_eng.buf_id = `OMM_BUF_EP0;
      OMM_RG_EP1O: o_eng.buf_id = `OMM_BUF_EP1O;
      OMM_RG_EP1I: o_eng.buf_id = `OMM_BUF_EP1I;
      OMM_RG_EPBIG: begin
        o_eng.buf_id = {1'b1, i_cpu.addr[11:9]};
        o_eng.offset = i_cpu.addr[8:0];
      end
      default: o_eng.buf_id = 4'h0;
    endcase
  end

  // ****************************************************************
  // On-chip memories
  // ****************************************************************
  logic [7:0] int_ram [`OMM_RAM_DEPTH];
  logic [7:0] scr_ram [`OMM_SCR_DEPTH];
  logic [7:0] wave_ram [`OMM_WAVE_DEPTH];
  logic [7:0] setup_buf [`OMM_SETUP_DEPTH];

  // Loader write lands after the processor one, so it wins a clash
  always_ff @(posedge i_ref_clk) begin
    if (i_cpu.wr && cpu_rg == OMM_RG_INTRAM)
      int_ram[i_cpu.addr[12:0]] <= i_cpu.wdata;
    if (ldr_ok && i_ldr.wr && ldr_rg == OMM_RG_INTRAM)
      int_ram[i_ldr.addr[12:0]] <= i_ldr.wdata;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_cpu.wr && cpu_rg == OMM_RG_SCRATCH)
      scr_ram[i_cpu.addr[8:0]] <= i_cpu.wdata;
    if (ldr_ok && i_ldr.wr && ldr_rg == OMM_RG_SCRATCH)
      scr_ram[i_ldr.addr[8:0]] <= i_ldr.wdata;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_cpu.wr && cpu_rg == OMM_RG_WAVE)
      wave_ram[i_cpu.addr[6:0]] <= i_cpu.wdata;
  end

  // Only the USB engine fills the setup buffer; processor writes drop
  always_ff @(posedge i_ref_clk) begin
    if (i_setup.wr) setup_buf[i_setup.idx] <= i_setup.data;
  end

  // ****************************************************************
  // Processor read path
  // ****************************************************************
  always_comb begin
    if (o_ext_fetch) cpu_val = i_ext_rdata;
    else if (ram_rd) cpu_val = int_ram[i_cpu.addr[12:0]];
    else begin
      case (cpu_rg)
        OMM_RG_SCRATCH: cpu_val = scr_ram[i_cpu.addr[8:0]];
        OMM_RG_WAVE:    cpu_val = wave_ram[i_cpu.addr[6:0]];
        OMM_RG_SETUP:   cpu_val = setup_buf[i_cpu.addr[2:0]];
        OMM_RG_REGS:    cpu_val = i_reg_rdata;
        OMM_RG_EP0, OMM_RG_EP1O, OMM_RG_EP1I,
        OMM_RG_EPBIG:   cpu_val = i_eng_rdata;
        OMM_RG_EXT:     cpu_val = i_ext_rdata;
        default:        cpu_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_cpu_rdata  <= 8'h00;
      o_cpu_rvalid <= 1'b0;
    end else begin
      o_cpu_rvalid <= i_cpu.rd || i_cpu.fetch;
      if (i_cpu.rd || i_cpu.fetch) o_cpu_rdata <= cpu_val;
    end
  end

  // ****************************************************************
  // Loader port
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_ldr_rdata <= 8'h00;
      o_ldr_ack   <= 1'b0;
      o_ldr_err   <= 1'b0;
    end else begin
      o_ldr_ack <= ldr_ok;
      o_ldr_err <= i_ldr.req && !ldr_ok;
      if (ldr_ok && !i_ldr.wr)
        o_ldr_rdata <= (ldr_rg == OMM_RG_INTRAM) ?
                       int_ram[i_ldr.addr[12:0]] :
                       scr_ram[i_ldr.addr[8:0]];
    end
  end

  // ****************************************************************
  // Endpoint configuration and alternate settings
  // ****************************************************************
  omm_ep_cfg u_ep_cfg (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_cfg_wr  (i_cfg_wr),
    .i_cfg     (i_cfg),
    .o_blk     (o_blk),
    .o_cfg     (o_cfg),
    .o_cfg_err (o_cfg_err)
  );

  omm_alt_rom u_alt_rom (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .i_alt     (i_alt),
    .o_row     (o_alt_row)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_ram_wr;
    i_cpu.wr && cpu_rg == OMM_RG_INTRAM && !i_ldr.req;
  endsequence
  sequence s_fetch_same;
    i_cpu.fetch && !i_code_source_select &&
    i_cpu.addr == $past(i_cpu.addr);
  endsequence
  property p_merge;
    s_ram_wr ##1 s_fetch_same |=> o_cpu_rdata == $past(i_cpu.wdata, 2);
  endproperty
  a_merge: assert property (p_merge)
    else $error("fetch did not return data written to internal RAM");

  property p_no_regs_low;
    (o_reg_rd || o_reg_wr) |-> i_cpu.addr > `OMM_RAM_LAST;
  endproperty
  a_no_regs_low: assert property (p_no_regs_low)
    else $error("register page selected in internal RAM range");

  property p_int_code;
    (i_cpu.fetch && !i_code_source_select &&
     i_cpu.addr <= `OMM_RAM_LAST) |-> !o_ext_fetch ##1 o_cpu_rvalid;
  endproperty
  a_int_code: assert property (p_int_code)
    else $error("internal code fetch went external");

  property p_suppress;
    ((i_cpu.rd || i_cpu.wr) && i_cpu.addr >= `OMM_SCR_BASE)
      |-> !o_ext_rd && !o_ext_wr;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("external strobe for an on-chip address");

  property p_ext_code;
    (i_cpu.fetch && i_code_source_select) |-> o_ext_fetch;
  endproperty
  a_ext_code: assert property (p_ext_code)
    else $error("fetch stayed internal with select high");

  property p_ldr_range;
    (i_ldr.req && i_ldr.addr > `OMM_RAM_LAST &&
     !(i_ldr.addr >= `OMM_SCR_BASE && i_ldr.addr <= `OMM_SCR_LAST))
      |=> o_ldr_err && !o_ldr_ack;
  endproperty
  a_ldr_range: assert property (p_ldr_range)
    else $error("loader reached memory outside the allowed ranges");

  sequence s_wave_wr;
    i_cpu.wr && i_cpu.addr >= `OMM_WAVE_BASE &&
    i_cpu.addr <= `OMM_WAVE_LAST;
  endsequence
  property p_wave;
    s_wave_wr ##1 (i_cpu.rd && i_cpu.addr == $past(i_cpu.addr))
      |=> o_cpu_rdata == $past(i_cpu.wdata, 2);
  endproperty
  a_wave: assert property (p_wave)
    else $error("waveform memory lost a written byte");

  property p_epbig;
    (i_cpu.rd && i_cpu.addr >= `OMM_EPB_BASE)
      |-> o_eng.sel && o_eng.buf_id == {1'b1, i_cpu.addr[11:9]} &&
          o_eng.offset == i_cpu.addr[8:0];
  endproperty
  a_epbig: assert property (p_epbig)
    else $error("endpoint block decode wrong");

  property p_resv;
    (i_cpu.rd &&
     ((i_cpu.addr > `OMM_SCR_LAST && i_cpu.addr < `OMM_WAVE_BASE) ||
      (i_cpu.addr > `OMM_WAVE_LAST && i_cpu.addr < `OMM_REG_BASE)))
      |-> !o_eng.sel ##1 o_cpu_rdata == 8'h00;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved gap did not read zero");

  sequence s_setup_wr;
    i_setup.wr;
  endsequence
  property p_setup;
    s_setup_wr ##1 (i_cpu.rd && !i_setup.wr &&
      i_cpu.addr == (`OMM_SETUP_BASE | {13'h0, $past(i_setup.idx)}))
      |=> o_cpu_rdata == $past(i_setup.data, 2);
  endproperty
  a_setup: assert property (p_setup)
    else $error("setup buffer byte not returned");

  property p_ep0;
    (i_cpu.rd && i_cpu.addr >= `OMM_EP0_BASE &&
     i_cpu.addr <= `OMM_EP0_LAST)
      |-> o_eng.sel && o_eng.buf_id == `OMM_BUF_EP0;
  endproperty
  a_ep0: assert property (p_ep0)
    else $error("endpoint 0 buffer not selected");

  // Bit 6 splits the two endpoint 1 buffers
  property p_ep1;
    (i_cpu.rd && i_cpu.addr >= `OMM_EP1O_BASE &&
     i_cpu.addr <= `OMM_EP1I_LAST)
      |-> o_eng.sel && o_eng.offset == {3'h0, i_cpu.addr[5:0]} &&
          o_eng.buf_id == (i_cpu.addr[6] ? `OMM_BUF_EP1I : `OMM_BUF_EP1O);
  endproperty
  a_ep1: assert property (p_ep1)
    else $error("endpoint 1 buffer decode wrong");

  property p_reg_page;
    (i_cpu.rd && i_cpu.addr >= `OMM_REG_BASE &&
     i_cpu.addr <= `OMM_REG_LAST &&
     !(i_cpu.addr >= `OMM_SETUP_BASE && i_cpu.addr <= `OMM_SETUP_LAST))
      |-> o_reg_rd && !o_eng.sel && !o_ext_rd;
  endproperty
  a_reg_page: assert property (p_reg_page)
    else $error("register page read not passed to the registers");

  property p_ldr_ok;
    (i_ldr.req && (i_ldr.addr <= `OMM_RAM_LAST ||
     (i_ldr.addr >= `OMM_SCR_BASE && i_ldr.addr <= `OMM_SCR_LAST)))
      |=> o_ldr_ack && !o_ldr_err;
  endproperty
  a_ldr_ok: assert property (p_ldr_ok)
    else $error("loader refused an allowed address");

endmodule : omm_decode
`default_nettype wire

/* testbench/omm_far_model.sv */
// Far side model: external memory, register page and endpoint buffers
`timescale 1ns/10ps
`default_nettype none
module omm_far_model import omm_pkg::*; (
  input  wire logic         i_ref_clk,
  input  wire omm_cpu_req_t i_cpu,
  input  wire logic         i_ext_on,
  input  wire logic         i_reg_rd,
  input  wire omm_eng_acc_t i_eng,
  output var  logic [7:0]   o_ext_rdata,
  output var  logic [7:0]   o_reg_rdata,
  output var  logic [7:0]   o_eng_rdata
);
  logic [7:0] churn_r;
  // Undriven buses churn so a stale value never passes for an answer
  always @(posedge i_ref_clk) churn_r <= churn_r + 8'h35;
  initial churn_r = 8'h00;
  always_comb o_ext_rdata = i_ext_on ? i_cpu.addr[7:0] ^ 8'h3C : churn_r;
  always_comb o_reg_rdata = i_reg_rd ? 8'hC3 : ~churn_r;
  always_comb o_eng_rdata = i_eng.sel ? i_eng.offset[7:0] : churn_r;
endmodule : omm_far_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the on-chip memory map decoder
`timescale 1ns/10ps
`default_nettype none
module testbench import omm_pkg::*;;
  logic i_ref_clk, i_rst_b, sel, cfg_wr, rv, rg;
  logic [7:0] rd, erd, rrd, grd, ld;
  logic [2:0] ex;
  logic [1:0] alt, la;
  omm_cpu_req_t cpu; omm_setup_wr_t su; omm_ldr_req_t ldr;
  omm_ep_cfg_t cfg, oc;
  omm_eng_acc_t eng, ge; omm_blk_t blk; omm_alt_row_t row;
  logic o_f, o_r, o_w, o_rr, o_rw, o_rv, o_ack, o_err, o_cerr;
  logic [7:0] o_rd, o_ld;
  int fail_count = 0, compares = 0;
  omm_decode omm_decode_i (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_code_source_select(sel), .i_cpu(cpu), .o_cpu_rdata(o_rd),
    .o_cpu_rvalid(o_rv), .o_ext_fetch(o_f), .o_ext_rd(o_r), .o_ext_wr(o_w),
    .i_ext_rdata(erd), .o_reg_rd(o_rr), .o_reg_wr(o_rw), .i_reg_rdata(rrd),
    .o_eng(eng), .i_eng_rdata(grd), .i_setup(su), .i_ldr(ldr),
    .o_ldr_rdata(o_ld), .o_ldr_ack(o_ack), .o_ldr_err(o_err),
    .i_cfg_wr(cfg_wr), .i_cfg(cfg), .o_blk(blk), .o_cfg(oc),
    .o_cfg_err(o_cerr), .i_alt(alt), .o_alt_row(row));
  omm_far_model omm_far_model_i (.i_ref_clk(i_ref_clk), .i_cpu(cpu),
    .i_ext_on(o_f | o_r), .i_reg_rd(o_rr), .i_eng(eng),
    .o_ext_rdata(erd), .o_reg_rdata(rrd), .o_eng_rdata(grd));
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One processor access; k is {fetch, rd, wr}
  task automatic acc(logic [15:0] a, logic [2:0] k, logic [7:0] d);
    @(posedge i_ref_clk) cpu <= '{a, k[2], k[1], k[0], d};
    su <= '0;
    #1 ex = {o_f, o_r, o_w}; rg = o_rr | o_rw; ge = eng;
    @(posedge i_ref_clk) cpu <= '{a, 1'b0, 1'b0, 1'b0, d};
    #1 rv = o_rv; rd = o_rd;
  endtask : acc
  // Write then access the same byte on the very next edge
  task automatic b2b(logic [15:0] a, logic [2:0] k, logic [7:0] d);
    @(posedge i_ref_clk) cpu <= '{a, 1'b0, 1'b0, 1'b1, d};
    #1 ex = {o_f, o_r, o_w};
    @(posedge i_ref_clk) cpu <= '{a, k[2], k[1], k[0], d};
    @(posedge i_ref_clk) cpu <= '{a, 1'b0, 1'b0, 1'b0, d};
    #1 rv = o_rv; rd = o_rd;
  endtask : b2b
  task automatic lda(logic w, logic [15:0] a, logic [7:0] d);
    @(posedge i_ref_clk) ldr <= '{1'b1, w, a, d};
    @(posedge i_ref_clk) ldr <= '{1'b0, 1'b0, a, d};
    #1 la = {o_ack, o_err}; ld = o_ld;
  endtask : lda
  task automatic t_ram;
    sel <= 1'b0; acc(16'h0123, 3'h1, 8'h5A); chk("ext", 0, ex);
    b2b(16'h0123, 3'h4, 8'h5A); chk("fetch", 16'h5A, rd);
    acc(16'h1FFF, 3'h1, 8'hA6); acc(16'h1FFF, 3'h2, 8'h00);
    chk("rd", 16'hA6, rd); chk("rv", 1, rv); chk("reg", 0, rg);
    @(posedge i_ref_clk) sel <= 1'b1;
    acc(16'h0010, 3'h4, 8'h00);
    chk("xf", 16'h4, ex); chk("xd", 16'h2C, rd);
    acc(16'h0123, 3'h2, 8'h00); chk("dram", 16'h5A, rd);
    acc(16'h2000, 3'h2, 8'h00); chk("xrd", 16'h2, ex);
  endtask : t_ram
  task automatic t_upper;
    b2b(16'hE47F, 3'h2, 8'h96);
    chk("wave", 16'h96, rd); chk("wx", 0, ex);
    acc(16'hE480, 3'h1, 8'h11); acc(16'hE480, 3'h2, 8'h00);
    chk("resv", 0, rd); chk("rx", 0, ex);
    acc(16'hE1FF, 3'h1, 8'h3B); acc(16'hE1FF, 3'h2, 8'h00);
    chk("scr", 16'h3B, rd);
    acc(16'hE600, 3'h2, 8'h00); chk("regp", 16'hC3, rd); chk("rg", 1, rg);
    @(posedge i_ref_clk) su <= '{1'b1, 3'h7, 8'h77};
    acc(16'hE6BF, 3'h2, 8'h00); chk("setup", 16'h77, rd);
    chk("srg", 0, rg);
    acc(16'hE7C5, 3'h2, 8'h00); chk("ep1i", 16'h2005, {ge.buf_id, 3'h0,
      ge.offset}); chk("e1d", 16'h05, rd);
    acc(16'hE745, 3'h2, 8'h00); chk("ep0", 16'h1, ge.sel);
    acc(16'hFE01, 3'h2, 8'h00); chk("big", 16'hF001, {ge.buf_id, 3'h0,
      ge.offset});
  endtask : t_upper
  task automatic t_ldr;
    lda(1'b1, 16'h1FFE, 8'hC4); chk("lack", 16'h2, la);
    lda(1'b0, 16'h1FFE, 8'h00); chk("lrd", 16'hC4, ld);
    lda(1'b1, 16'hE000, 8'h21); chk("lscr", 16'h2, la);
    lda(1'b1, 16'hE400, 8'h21); chk("lerr", 16'h1, la);
    lda(1'b0, 16'hF000, 8'h00); chk("lerr2", 16'h1, la);
  endtask : t_ldr
  task automatic cfgw(omm_ep_cfg_t c, logic e, omm_blk_t b);
    @(posedge i_ref_clk) begin
      cfg <= c;
      cfg_wr <= 1'b1;
    end
    @(posedge i_ref_clk) cfg_wr <= 1'b0;
    #1 chk("cerr", e, o_cerr);
    if (!e) chk("blk", b, blk);
    if (!e) chk("cfg", c, oc);
  endtask : cfgw
  task automatic t_cfg;
    cfgw('{0, 0, 3'h4, 3'h2, OMM_INT, OMM_ISO, OMM_BULK, OMM_INT, OMM_ISO},
      0, '{3'h4, 3'h0, 3'h2, 3'h2});
    cfgw('{1, 1, 3'h2, 3'h2, OMM_BULK, OMM_BULK, OMM_BULK, OMM_BULK,
      OMM_BULK}, 0, '{3'h3, 3'h2, 3'h3, 3'h0});
    cfgw('{0, 0, 3'h2, 3'h2, OMM_CTRL, OMM_BULK, OMM_BULK, OMM_BULK,
      OMM_BULK}, 1, blk);
    cfgw('{0, 0, 3'h2, 3'h2, OMM_BULK, OMM_CTRL, OMM_BULK, OMM_BULK,
      OMM_BULK}, 1, blk);
  endtask : t_cfg
  task automatic t_alt;
    chk("a0", {7'h40, OMM_CTRL, 1'b0}, row.ep0);
    chk("a0z", 0, row.ep1o.size);
    @(posedge i_ref_clk) alt <= 2'h3;
    @(posedge i_ref_clk) #1 chk("a3", {7'h40, OMM_ISO, 1'b1}, row.ep2);
    chk("a3i", {7'h40, OMM_INT, 1'b0}, row.ep1i);
    @(posedge i_ref_clk) alt <= 2'h2;
    @(posedge i_ref_clk) #1 chk("a2", {7'h40, OMM_BULK, 1'b1}, row.ep8);
  endtask : t_alt
  task automatic report_and_stop;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  initial begin
    i_rst_b = 1'b0; sel = 1'b0; cfg_wr = 1'b0; alt = 2'h0;
    cpu = '0; su = '0; ldr = '0; cfg = '0;
    repeat (10) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    #1 t_alt();
    @(posedge i_ref_clk) alt <= 2'h0;
    t_ram(); t_upper(); t_ldr(); t_cfg();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
